// ===== shared/rx_sync_pkg.sv
// package of constants and carriers for the receive framer sync and line port block
package rx_sync_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int SYS_CLK_HZ = 20000000;
  localparam int LINK_CLK_PERIOD_NS = 400;
  localparam int SYS_CLK_PERIOD_NS = 1000000000 / SYS_CLK_HZ;
  // recovered line clock is sampled; its period in sys_clk cycles, rounded down
  localparam int LINK_CLK_CYCLES = LINK_CLK_PERIOD_NS / SYS_CLK_PERIOD_NS;

  // ****************************************
  // framing geometry
  // ****************************************
  localparam logic [9:0] T1_FRAME_BITS = 10'h0C1;
  localparam logic [9:0] E1_FRAME_BITS = 10'h100;
  localparam logic [4:0] T1_MF_FRAMES = 5'h0C;
  localparam logic [4:0] E1_MF_FRAMES = 5'h10;
  // signaling frames in a T1 superframe: 6 and 12 (counts 5 and 11)
  localparam logic [4:0] T1_SIG_FRAME_A = 5'h05;
  localparam logic [4:0] T1_SIG_FRAME_B = 5'h0B;

  // ****************************************
  // register interface
  // ****************************************
  localparam logic [3:0] REG_IO_CONFIG_ONE = 4'h0;
  localparam logic [3:0] REG_LINE_STATUS = 4'h1;
  localparam logic [3:0] REG_FIFO_DATA = 4'h2;
  localparam logic [7:0] IO_CONFIG_RESET = 8'h00;
  // bit positions inside framer_io_config_one
  localparam int CFG_E1_MODE = 0;
  localparam int CFG_ES_ENABLE = 1;
  localparam int CFG_SYNC_INPUT = 4;
  localparam int CFG_SYNC_MF = 5;
  localparam int CFG_SYNC_DOUBLE = 6;

  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  // one captured received bit pair, positive and negative line
  typedef struct packed {
    logic pos;
    logic neg;
  } line_pair_t;

  // configuration decoded from framer_io_config_one
  typedef struct packed {
    logic double_sig;
    logic sync_mf;
    logic sync_input;
    logic es_enable;
    logic e1_mode;
  } cfg_t;

endpackage

// ===== core/rx_byte_fifo.sv
// small synchronous FIFO holding received framer bytes
`timescale 1ns/1ps
`default_nettype none
module rx_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];

  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_wr) begin
        wr_q <= AW'(wr_q + 1'b1);
      end
      if (do_rd) begin
        rd_q <= AW'(rd_q + 1'b1);
      end
      if (do_wr && !do_rd) begin
        cnt_q <= (AW+1)'(cnt_q + 1'b1);
      end else if (do_rd && !do_wr) begin
        cnt_q <= (AW+1)'(cnt_q - 1'b1);
      end
    end
  end
endmodule
`default_nettype wire

// ===== core/rx_framer_sync.sv
// receive framer sync generation, line unit joining and received data path
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module rx_framer_sync
  import rx_sync_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // line unit side, from the network
  input wire logic line_recovered_clock,
  input wire logic line_pos_raw,
  input wire logic line_neg_raw,
  output logic rx_recovered_clock_out,
  output logic rx_positive_line_out,
  output logic rx_negative_line_out,
  // framer interim inputs
  input wire logic rx_framer_line_clock_in,
  input wire logic rx_positive_framer_in,
  input wire logic rx_negative_framer_in,
  input wire logic line_unit_connect,
  // transmit clock joining
  input wire logic tx_formatter_clock_out,
  input wire logic tx_line_clock_in,
  output logic tx_line_clock_sel,
  // system clock behind the elastic store
  input wire logic rx_system_clock,
  // sync pin, two-way
  input wire logic rx_sync_pin_i,
  output logic rx_sync_pin_o,
  output logic rx_sync_pin_oe,
  // framer outputs
  output logic rx_framer_clock_out,
  output logic rx_frame_sync_pre_store,
  output logic rx_multiframe_sync,
  output logic rx_signaling_out,
  output logic rx_framer_data_out
);
  import rx_sync_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  // bit order: sysclk, txfmt, txin, lclk, lpos, lneg, fclk, fpos, fneg, strap, sync
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  assign pins_raw = {rx_system_clock, tx_formatter_clock_out, tx_line_clock_in,
                     line_recovered_clock, line_pos_raw, line_neg_raw,
                     rx_framer_line_clock_in, rx_positive_framer_in,
                     rx_negative_framer_in, line_unit_connect, rx_sync_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= pins_raw[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  wire s_sysclk = sync_q[10];
  wire s_txfmt = sync_q[9];
  wire s_txin = sync_q[8];
  wire s_lclk = sync_q[7];
  wire s_lpos = sync_q[6];
  wire s_lneg = sync_q[5];
  wire s_fclk = sync_q[4];
  wire s_fpos = sync_q[3];
  wire s_fneg = sync_q[2];
  wire s_strap = sync_q[1];
  wire s_sync = sync_q[0];

  // ****************************************
  // configuration register
  // ****************************************
  logic [7:0] cfg_q;
  cfg_t cfg;
  assign cfg = '{double_sig: cfg_q[CFG_SYNC_DOUBLE], sync_mf: cfg_q[CFG_SYNC_MF],
                 sync_input: cfg_q[CFG_SYNC_INPUT], es_enable: cfg_q[CFG_ES_ENABLE],
                 e1_mode: cfg_q[CFG_E1_MODE]};
  // input direction only legal with the store enabled
  wire sync_is_input = cfg.sync_input && cfg.es_enable;

  // ****************************************
  // line unit outputs and joining
  // ****************************************
  logic lclk_d1_q;
  logic fclk_d1_q;
  logic sys_d1_q;
  wire lclk_rise = s_lclk && !lclk_d1_q;
  // strap high: internal join, interim input pins ignored
  wire join_now = s_strap;
  wire fr_clk = join_now ? s_lclk : s_fclk;
  wire fr_fall = fclk_d1_q && !fr_clk;
  wire fr_rise = !fclk_d1_q && fr_clk;
  line_pair_t lu_q;
  line_pair_t fr_in;
  assign fr_in = join_now ? lu_q : '{pos: s_fpos, neg: s_fneg};
  // store clock used only with store enabled; held-low pin then never edges
  wire sys_rise = cfg.es_enable && s_sysclk && !sys_d1_q;
  wire out_tick = cfg.es_enable ? sys_rise : fr_rise;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lclk_d1_q <= 1'b0;
      fclk_d1_q <= 1'b0;
      sys_d1_q <= 1'b0;
      lu_q <= '0;
      rx_recovered_clock_out <= 1'b0;
      rx_positive_line_out <= 1'b0;
      rx_negative_line_out <= 1'b0;
      tx_line_clock_sel <= 1'b0;
      rx_framer_clock_out <= 1'b0;
    end else begin
      lclk_d1_q <= s_lclk;
      fclk_d1_q <= fr_clk;
      sys_d1_q <= s_sysclk;
      rx_recovered_clock_out <= s_lclk;
      rx_framer_clock_out <= fr_clk;
      tx_line_clock_sel <= join_now ? s_txfmt : s_txin;
      if (lclk_rise) begin
        lu_q <= '{pos: s_lpos, neg: s_lneg};
        rx_positive_line_out <= s_lpos;
        rx_negative_line_out <= s_lneg;
      end
    end
  end

  // ****************************************
  // frame and multiframe counters
  // ****************************************
  logic [9:0] bit_q;
  logic [4:0] frm_q;
  logic sample_q;
  logic [7:0] shift_q;
  logic [2:0] nbits_q;
  wire [9:0] frame_len = cfg.e1_mode ? E1_FRAME_BITS : T1_FRAME_BITS;
  wire [4:0] mf_len = cfg.e1_mode ? E1_MF_FRAMES : T1_MF_FRAMES;
  // compare by >= so a mode change with a high count ends the frame at once
  wire frame_end = (bit_q >= frame_len - 10'h001);
  wire mf_end = frame_end && (frm_q >= mf_len - 5'h01);
  // NRZ drives both inputs alike; OR keeps the bit either way
  wire rx_bit = fr_in.pos || fr_in.neg;
  wire sig_frame = !cfg.e1_mode && (frm_q == T1_SIG_FRAME_A || frm_q == T1_SIG_FRAME_B);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bit_q <= '0;
      frm_q <= '0;
      sample_q <= 1'b0;
    end else if (fr_fall) begin
      sample_q <= rx_bit;
      bit_q <= frame_end ? 10'h000 : 10'(bit_q + 10'h001);
      if (frame_end) begin
        frm_q <= mf_end ? 5'h00 : 5'(frm_q + 5'h01);
      end
    end
  end

  // ****************************************
  // sync pulses and data outputs
  // ****************************************
  logic fsync_q;
  logic msync_q;
  logic mf_pend_q;
  logic sync_o_q;
  logic sync_ext_d1_q;
  logic sig_q;
  wire bound_now = cfg.sync_mf ? (bit_q == 10'h000 && frm_q == 5'h00) : (bit_q == 10'h000);
  wire dbl_now = !cfg.sync_mf && cfg.double_sig && sig_frame && bit_q == 10'h001;
  wire ext_rise = s_sync && !sync_ext_d1_q;
  wire mf_bound = (bit_q == 10'h000) && (frm_q == 5'h00);
  // store off: aligned with the sync pin; store on: retimed to the store clock
  wire msync_next = cfg.es_enable ? (mf_pend_q || (sync_is_input && ext_rise)) : mf_bound;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_frame_sync_pre_store <= 1'b0;
      rx_multiframe_sync <= 1'b0;
      rx_signaling_out <= 1'b0;
      rx_framer_data_out <= 1'b0;
      rx_sync_pin_o <= 1'b0;
      rx_sync_pin_oe <= 1'b0;
      fsync_q <= 1'b0;
      msync_q <= 1'b0;
      mf_pend_q <= 1'b0;
      sync_o_q <= 1'b0;
      sync_ext_d1_q <= 1'b0;
      sig_q <= 1'b0;
    end else begin
      sync_ext_d1_q <= s_sync;
      rx_sync_pin_oe <= !sync_is_input;
      if (fr_rise) begin
        fsync_q <= (bit_q == 10'h000);
        sync_o_q <= bound_now || dbl_now;
        rx_frame_sync_pre_store <= (bit_q == 10'h000);
        rx_sync_pin_o <= sync_is_input ? 1'b0 : (bound_now || dbl_now);
        rx_framer_data_out <= sample_q;
        if (sig_frame) begin
          sig_q <= sample_q;
        end
      end
      // boundary seen on the framer side, held until the output clock takes it
      if (fr_rise && bit_q == 10'h000 && frm_q == 5'h00) begin
        mf_pend_q <= 1'b1;
      end else if (out_tick) begin
        mf_pend_q <= 1'b0;
      end
      if (out_tick) begin
        msync_q <= msync_next;
        rx_multiframe_sync <= msync_next;
        rx_signaling_out <= sig_q;
      end
    end
  end

  // ****************************************
  // received byte buffer for register readout
  // ****************************************
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic fifo_in_ready;
  wire byte_done = fr_fall && (nbits_q == 3'h7);
  wire fifo_pop = reg_rd && (reg_addr == REG_FIFO_DATA);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shift_q <= '0;
      nbits_q <= '0;
    end else if (fr_fall && fifo_in_ready) begin
      shift_q <= {shift_q[6:0], rx_bit};
      nbits_q <= 3'(nbits_q + 3'h1);
    end
  end

  rx_byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(byte_done && fifo_in_ready),
    .in_ready(fifo_in_ready),
    .in_data({shift_q[6:0], rx_bit}),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ****************************************
  // register port
  // ****************************************
  wire [7:0] status_word = {2'b00, fifo_in_ready, fifo_valid, s_strap, fsync_q, msync_q, sync_o_q};
  wire [7:0] rd_mux = (reg_addr == REG_IO_CONFIG_ONE) ? cfg_q :
                      (reg_addr == REG_LINE_STATUS) ? status_word :
                      (reg_addr == REG_FIFO_DATA) ? (fifo_valid ? fifo_data : 8'h00) : 8'h00;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= IO_CONFIG_RESET;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == REG_IO_CONFIG_ONE) begin
        cfg_q <= reg_wdata;
      end
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_fsync_one_wide: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(rx_frame_sync_pre_store) |=> ##[1:20] !rx_frame_sync_pre_store)
    else $error("frame sync wider than one framer clock");
  chk_sync_oe_input: assert property (@(posedge sys_clk) disable iff (rst)
    (cfg.sync_input && cfg.es_enable) |=> !rx_sync_pin_oe)
    else $error("sync pin driven while configured as input");
  chk_sync_no_input: assert property (@(posedge sys_clk) disable iff (rst)
    !cfg.es_enable |=> rx_sync_pin_oe)
    else $error("sync pin not driven with store off");
  chk_join_clock: assert property (@(posedge sys_clk) disable iff (rst)
    (s_strap && $stable(s_strap)) |=> rx_framer_clock_out == $past(s_lclk))
    else $error("framer clock not joined to recovered clock");
  chk_recov_copy: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 rx_recovered_clock_out == $past(s_lclk))
    else $error("recovered clock output not a copy");
  chk_line_update: assert property (@(posedge sys_clk) disable iff (rst)
    !lclk_rise |=> $stable(rx_positive_line_out) && $stable(rx_negative_line_out))
    else $error("line data changed off recovered clock rise");
  chk_data_on_rise: assert property (@(posedge sys_clk) disable iff (rst)
    !fr_rise |=> $stable(rx_framer_data_out))
    else $error("framer data changed off framer clock rise");
  chk_sysclk_unused: assert property (@(posedge sys_clk) disable iff (rst)
    (!cfg.es_enable && !fr_rise) |=> $stable(rx_signaling_out) && $stable(rx_multiframe_sync))
    else $error("system clock used with store disabled");
  chk_tx_join: assert property (@(posedge sys_clk) disable iff (rst)
    (s_strap && $stable(s_strap)) |=> tx_line_clock_sel == $past(s_txfmt))
    else $error("transmit clock not joined");
endmodule
`default_nettype wire

// ===== test/line_unit_model.sv
// line unit model: free-running recovered clock with nrz data
`timescale 1ns/1ps
`default_nettype none
module line_unit_model #(
  parameter int HALF_NS = 200
) (
  // toward the block
  output logic rec_clk,
  output logic pos,
  output logic neg
);
  logic [7:0] pat;

  initial begin
    rec_clk = 1'b0;
    pos = 1'b0;
    neg = 1'b1;
    pat = 8'h5a;
    // odd offset keeps the line clock edges clear of the sys_clk edges
    #37;
    forever begin
      #HALF_NS rec_clk = ~rec_clk;
      if (rec_clk) begin
        pat = {pat[6:0], pat[7]};
        pos = pat[7];
        neg = pat[7];
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/rx_framer_sync_tb.sv
// self-checking bench for the receive framer sync and line port block
`timescale 1ns/1ps
`default_nettype none
module rx_framer_sync_tb;
  import rx_sync_pkg::*;

  // ****************************************
  // stimulus and monitors
  // ****************************************
  typedef struct {logic [7:0] cfg; logic conn; logic oe;} row_t;
  logic sys_clk, rst, reg_wr, reg_rd, conn, ifc_clk;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, d;
  logic [4:0] mon_q;
  int err_count, check_count, cyc, p, w, n;
  wire logic [7:0] reg_rdata;
  wire logic lu_clk, lu_pos, lu_neg, rco, rpo, rno, txsel, so, soe;
  wire logic fco, fss, mfs, sig, fdo;
  // no pull on the sync pin; the bench holds it low while the block listens
  wire logic sync_wire = soe ? so : 1'b0;
  wire logic [4:0] mon = {fco, rco, mfs, fss, so};
  wire logic [4:0] rise = mon & ~mon_q;
  row_t rows [5] = '{'{8'h00, 1'b0, 1'b1}, '{8'h10, 1'b1, 1'b1}, '{8'h12, 1'b0, 1'b0},
                     '{8'h02, 1'b1, 1'b1}, '{8'h61, 1'b1, 1'b1}};

  line_unit_model line_unit_model_inst (.rec_clk(lu_clk), .pos(lu_pos), .neg(lu_neg));

  rx_framer_sync rx_framer_sync_inst (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .line_recovered_clock(lu_clk), .line_pos_raw(lu_pos), .line_neg_raw(lu_neg),
    .rx_recovered_clock_out(rco), .rx_positive_line_out(rpo), .rx_negative_line_out(rno),
    .rx_framer_line_clock_in(ifc_clk), .rx_positive_framer_in(1'b0),
    .rx_negative_framer_in(1'b0), .line_unit_connect(conn),
    .tx_formatter_clock_out(1'b1), .tx_line_clock_in(1'b0), .tx_line_clock_sel(txsel),
    .rx_system_clock(1'b0),
    .rx_sync_pin_i(sync_wire), .rx_sync_pin_o(so), .rx_sync_pin_oe(soe),
    .rx_framer_clock_out(fco), .rx_frame_sync_pre_store(fss),
    .rx_multiframe_sync(mfs), .rx_signaling_out(sig), .rx_framer_data_out(fdo));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    mon_q <= mon;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      print_verdict();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask

  // cycles from one rise of a monitor to the next, and the pulse width
  task automatic gap(input int i);
    int k;
    k = 0;
    @(posedge sys_clk);
    while (!rise[i] && k < 40000) begin
      @(posedge sys_clk);
      k++;
    end
    p = 0;
    w = 1;
    do begin
      @(posedge sys_clk);
      p++;
      if (!rise[i] && mon[i]) w++;
    end while (!rise[i] && p < 40000);
  endtask

  task automatic rises(input int i);
    n = 0;
    repeat (160) begin
      @(posedge sys_clk);
      n += int'(rise[i]);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    conn = 1'b0;
    ifc_clk = 1'b0;
    err_count = 0;
    check_count = 0;
    cyc = 0;
    repeat (3) @(posedge sys_clk);
    check({10'h000, so, soe, fss, mfs, rco, fco}, 16'h0000);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(16'(soe), 16'h0001);
    $display("reset test done");
    foreach (rows[i]) begin
      conn <= rows[i].conn;
      wr(REG_IO_CONFIG_ONE, rows[i].cfg);
      repeat (6) @(posedge sys_clk);
      rd(REG_IO_CONFIG_ONE);
      check(16'(d), 16'(rows[i].cfg));
      rd(REG_LINE_STATUS);
      check(16'(d & 8'h08), {12'h000, rows[i].conn, 3'h0});
      check({14'h0000, soe, txsel}, {14'h0000, rows[i].oe, rows[i].conn});
    end
    $display("table test done");
    wr(4'h3, 8'hff);
    for (int a = 3; a < 16; a++) begin
      rd(4'(a));
      check(16'(d), 16'h0000);
    end
    rd(REG_IO_CONFIG_ONE);
    check(16'(d), 16'h0061);
    $display("unmapped test done");
    gap(1);
    check(16'(p), 16'(256 * 8));
    check(16'(w), 16'h0008);
    wr(REG_IO_CONFIG_ONE, 8'h00);
    gap(0);
    check(16'(p), 16'(193 * 8));
    check(16'(w), 16'h0008);
    gap(1);
    check(16'(p), 16'(193 * 8));
    rises(3);
    check(16'(n), 16'h0014);
    rises(4);
    check(16'(n), 16'h0014);
    $display("framing test done");
    wr(REG_IO_CONFIG_ONE, 8'h20);
    gap(0);
    check(16'(p), 16'(12 * 193 * 8));
    check(16'(mon[2]), 16'h0001);
    $display("multiframe test done");
    // double-wide pulses: one superframe holds 10 single and 2 double pulses
    wr(REG_IO_CONFIG_ONE, 8'h40);
    repeat (20) @(posedge sys_clk);
    n = 0;
    repeat (12 * 193 * 8) begin
      @(posedge sys_clk);
      n += int'(mon[0]);
    end
    check(16'(n), 16'(10 * 8 + 2 * 16));
    $display("double pulse test done");
    // the fifo has been filling all along with nobody draining it
    rd(REG_LINE_STATUS);
    check(16'(d & 8'h30), 16'h0010);
    conn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rises(4);
    check(16'(n), 16'h0000);
    repeat (8) rd(REG_FIFO_DATA);
    rd(REG_LINE_STATUS);
    check(16'(d & 8'h30), 16'h0020);
    $display("strap and fifo test done");
    print_verdict();
  end
endmodule
`default_nettype wire
